// >>> hw/ppi_regs.svh
`ifndef PPI_REGS_SVH
`define PPI_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define PPI_ADR_CTRL 8'h00
`define PPI_ADR_STATUS 8'h04
`define PPI_ADR_PINCFG 8'h08
`define PPI_ADR_DADDR 8'h0C
`define PPI_ADR_DDATA 8'h10
`define PPI_ADR_COMMIT 8'h14
`define PPI_ADR_FLAGCFG 8'h18
// ****************************************
// field positions
// ****************************************
`define PPI_CTRL_EN 0
`define PPI_CTRL_MST 1
`define PPI_CTRL_WID 2
`define PPI_CTRL_EXT 4
`define PPI_ST_PH 8
`define PPI_ST_DVAL 10
`define PPI_ST_RUN 11
`define PPI_ST_LVL 16
`define PPI_PIN_BID 16
`define PPI_FLG_A 0
`define PPI_FLG_AEN 5
`define PPI_FLG_B 8
`define PPI_FLG_BEN 13
`define PPI_D0_NXT_T 0
`define PPI_D0_NXT_F 8
`define PPI_D0_SEL 16
`define PPI_D0_POL 20
`define PPI_D0_DRV 21
`define PPI_D0_CAP 22
`define PPI_D0_SER 23
`define PPI_D1_OE 16
// ****************************************
// sizes, pins and timing
// ****************************************
`define PPI_MEM_WORDS 2048
`define PPI_W0_OFS 3'h0
`define PPI_W1_OFS 3'h1
`define PPI_CTL_MASK16 16'hFFFF
`define PPI_CTL_MASK14 16'h3FFF
`define PPI_LANE8 32'h0000_00FF
`define PPI_LANE16 32'h0000_FFFF
`define PPI_LANE32 32'hFFFF_FFFF
`define PPI_LANE1 32'h0000_0001
`define PPI_SEL_PIN 0
`define PPI_BUF_PIN 3
`define PPI_FLAG_A_PIN 12
`define PPI_FLAG_B_PIN 13
`define PPI_BCNT_LAST 5'h1F
`define PPI_FIFO_DEPTH 16
`define PPI_REF_MHZ 200
`define PPI_IF_MAX_MHZ 100
`define PPI_MIN_HOLD ((`PPI_REF_MHZ + `PPI_IF_MAX_MHZ - 1) / `PPI_IF_MAX_MHZ)
`endif

// >>> hw/ppi_pkg.sv
package ppi_pkg;
`include "ppi_regs.svh"
   // ****************************************
   // engine phases and bus widths
   // ****************************************
   typedef enum logic [1:0] {
      PPI_IDLE = 2'h0,
      PPI_FETCH_A = 2'h1,
      PPI_FETCH_B = 2'h3,
      PPI_RUN = 2'h2
   } ppi_phase_type;
   typedef enum logic [1:0] {
      PPI_W8 = 2'h0,
      PPI_W16 = 2'h1,
      PPI_W32 = 2'h2
   } ppi_width_type;
   // ****************************************
   // core state
   // ****************************************
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic en;
      logic mst;
      logic ext;
      ppi_width_type wid;
      logic [15:0] oen;
      logic [15:0] bid;
      logic [10:0] daddr;
      logic dval;
      logic [4:0] fa;
      logic [4:0] fb;
      logic fae;
      logic fbe;
      ppi_phase_type ph;
      logic [7:0] cur;
      logic [31:0] d0;
      logic [15:0] cs1;
      logic [15:0] cs2;
      logic [31:0] ps1;
      logic [31:0] ps2;
      logic [15:0] ctl_o;
      logic [15:0] ctl_oe;
      logic [31:0] pd_o;
      logic [31:0] pd_oe;
      logic [31:0] tx;
      logic txf;
      logic in_rdy;
      logic [31:0] rx;
      logic [4:0] bcnt;
   } ppi_state_type;
endpackage

// >>> hw/ppi_fifo.sv
`timescale 1ns/1ps
module ppi_fifo #(
   parameter int W = 37,
   parameter int D = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   input wire logic out_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   output logic [$clog2(D):0] level
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } ppi_fifo_state_type;
   ppi_fifo_state_type q, d;
   logic push, pop;
   // ring buffer with a registered output word
   always_comb begin
      d = q;
      push = in_valid && (q.cnt != FULL);
      pop = (q.cnt != '0) && (!q.ov || out_ready);
      if (pop) begin
         d.od = q.mem[q.rp];
         d.ov = 1'b1;
         d.rp = q.rp + 1'b1;
      end else if (out_ready) begin
         d.ov = 1'b0;
      end
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = q.wp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
   assign in_ready = (q.cnt != FULL);
   assign out_valid = q.ov;
   assign out_data = q.od;
   assign level = q.cnt;
endmodule

// >>> hw/ppi_wave_mem.sv
`timescale 1ns/1ps
`include "ppi_regs.svh"
module ppi_wave_mem (
   input wire logic clk,
   input wire logic ce,
   input wire logic we,
   input wire logic [10:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic re,
   input wire logic [10:0] raddr,
   output logic [31:0] rdata
);
   logic [31:0] mem [0:`PPI_MEM_WORDS-1];
   // one write port, one registered read port
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         if (re) begin
            rdata <= mem[raddr];
         end
      end
   end
endmodule

// >>> hw/ppi_core.sv
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ppi_regs.svh"
module ppi_core (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] ctl_i,
   output logic [15:0] ctl_o,
   output logic [15:0] ctl_oe,
   input wire logic [31:0] pd_i,
   output logic [31:0] pd_o,
   output logic [31:0] pd_oe,
   input wire logic [31:0] buf_ready_i,
   output logic dma_out_valid,
   input wire logic dma_out_ready,
   output logic [31:0] dma_out_data,
   output logic [4:0] dma_out_buf,
   input wire logic dma_in_valid,
   input wire logic [31:0] dma_in_data,
   output logic dma_in_ready
);
   // ****************************************
   // helpers
   // ****************************************
   // byte-enable merge of a write into a register word
   function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction
   // data lanes in use for a bus width
   function automatic logic [31:0] lanes(input ppi_pkg::ppi_width_type w);
      logic [31:0] r;
      r = `PPI_LANE8;
      case (w)
         ppi_pkg::PPI_W16: r = `PPI_LANE16;
         ppi_pkg::PPI_W32: r = `PPI_LANE32;
         default: r = `PPI_LANE8;
      endcase
      return r;
   endfunction
   // control pins present for a bus width
   function automatic logic [15:0] avail(input ppi_pkg::ppi_width_type w);
      return (w == ppi_pkg::PPI_W32) ? `PPI_CTL_MASK14 : `PPI_CTL_MASK16;
   endfunction
   // buffer number from the address pins
   function automatic logic [4:0] bufsel(input logic [15:0] cs, input logic ext);
      logic [4:0] r;
      r = cs[`PPI_BUF_PIN +: 5];
      if (!ext) begin
         r[4:2] = 3'h0;
      end
      return r;
   endfunction
   // ****************************************
   // state and datapath nets
   // ****************************************
   ppi_pkg::ppi_state_type q, d;
   logic mem_we, mem_re;
   logic [10:0] mem_ra;
   logic [31:0] mem_rd;
   logic fifo_wr, fifo_rdy;
   logic [36:0] fifo_in, fifo_out;
   logic [4:0] fifo_lvl;
   logic cond, push, stall, ser, cap, drv, live;
   logic [7:0] nxt;
   logic [31:0] ctrl_rd, pin_rd, flag_rd, st_rd, wv, lm;
   logic [15:0] am;
   logic [7:0] nxt_t, nxt_f;
   logic [15:0] d1_lo;
   assign nxt_t = q.d0[`PPI_D0_NXT_T +: 8];
   assign nxt_f = q.d0[`PPI_D0_NXT_F +: 8];
   assign d1_lo = mem_rd[15:0];
   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d = q;
      mem_we = 1'b0;
      mem_re = 1'b0;
      mem_ra = '0;
      fifo_wr = 1'b0;
      fifo_in = '0;
      cond = 1'b0;
      nxt = '0;
      push = 1'b0;
      stall = 1'b0;
      wv = '0;
      ser = q.d0[`PPI_D0_SER];
      cap = q.d0[`PPI_D0_CAP];
      drv = q.d0[`PPI_D0_DRV];
      live = q.en && q.dval;
      lm = lanes(q.wid);
      am = avail(q.wid);
      // readable register images
      ctrl_rd = '0;
      ctrl_rd[`PPI_CTRL_EN] = q.en;
      ctrl_rd[`PPI_CTRL_MST] = q.mst;
      ctrl_rd[`PPI_CTRL_WID +: 2] = q.wid;
      ctrl_rd[`PPI_CTRL_EXT] = q.ext;
      pin_rd = {q.bid, q.oen};
      flag_rd = '0;
      flag_rd[`PPI_FLG_A +: 5] = q.fa;
      flag_rd[`PPI_FLG_AEN] = q.fae;
      flag_rd[`PPI_FLG_B +: 5] = q.fb;
      flag_rd[`PPI_FLG_BEN] = q.fbe;
      st_rd = '0;
      st_rd[7:0] = q.cur;
      st_rd[`PPI_ST_PH +: 2] = q.ph;
      st_rd[`PPI_ST_DVAL] = q.dval;
      st_rd[`PPI_ST_RUN] = (q.ph != ppi_pkg::PPI_IDLE);
      st_rd[`PPI_ST_LVL +: 5] = fifo_lvl;
      // two-stage pin synchronisers
      d.cs1 = ctl_i;
      d.cs2 = q.cs1;
      d.ps1 = pd_i;
      d.ps2 = q.ps1;
      // wishbone slave, one wait state, zero on unmapped reads
      d.ack = 1'b0;
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         d.ack = 1'b1;
         d.rdat = '0;
         if (wb_we_i) begin
            case (wb_adr_i)
               `PPI_ADR_CTRL: begin
                  wv = wmask(ctrl_rd, wb_dat_i, wb_sel_i);
                  d.en = wv[`PPI_CTRL_EN];
                  d.mst = wv[`PPI_CTRL_MST];
                  d.wid = ppi_pkg::ppi_width_type'(wv[`PPI_CTRL_WID +: 2]);
                  d.ext = wv[`PPI_CTRL_EXT];
               end
               `PPI_ADR_PINCFG: begin
                  wv = wmask(pin_rd, wb_dat_i, wb_sel_i);
                  d.oen = wv[15:0];
                  d.bid = wv[`PPI_PIN_BID +: 16];
               end
               `PPI_ADR_DADDR: begin
                  wv = wmask({21'h0, q.daddr}, wb_dat_i, wb_sel_i);
                  d.daddr = wv[10:0];
               end
               `PPI_ADR_DDATA: begin
                  mem_we = 1'b1;
                  d.daddr = q.daddr + 1'b1;
                  d.dval = 1'b0;
               end
               `PPI_ADR_COMMIT: begin
                  d.dval = wb_dat_i[0];
               end
               `PPI_ADR_FLAGCFG: begin
                  wv = wmask(flag_rd, wb_dat_i, wb_sel_i);
                  d.fa = wv[`PPI_FLG_A +: 5];
                  d.fae = wv[`PPI_FLG_AEN];
                  d.fb = wv[`PPI_FLG_B +: 5];
                  d.fbe = wv[`PPI_FLG_BEN];
               end
               default: d.rdat = '0;
            endcase
         end else begin
            case (wb_adr_i)
               `PPI_ADR_CTRL: d.rdat = ctrl_rd;
               `PPI_ADR_STATUS: d.rdat = st_rd;
               `PPI_ADR_PINCFG: d.rdat = pin_rd;
               `PPI_ADR_DADDR: d.rdat = {21'h0, q.daddr};
               `PPI_ADR_COMMIT: d.rdat = {31'h0, q.dval};
               `PPI_ADR_FLAGCFG: d.rdat = flag_rd;
               default: d.rdat = '0;
            endcase
         end
      end
      // descriptor engine
      unique case (q.ph)
         ppi_pkg::PPI_IDLE: begin
            // slave waits for the far party's select pin
            if (live && (q.mst || q.cs2[`PPI_SEL_PIN])) begin
               d.ph = ppi_pkg::PPI_FETCH_A;
               d.cur = '0;
               d.bcnt = '0;
            end
         end
         ppi_pkg::PPI_FETCH_A: begin
            mem_re = 1'b1;
            mem_ra = {q.cur, `PPI_W0_OFS};
            d.ph = ppi_pkg::PPI_FETCH_B;
         end
         ppi_pkg::PPI_FETCH_B: begin
            mem_re = 1'b1;
            mem_ra = {q.cur, `PPI_W1_OFS};
            d.d0 = mem_rd;
            d.ph = ppi_pkg::PPI_RUN;
         end
         ppi_pkg::PPI_RUN: begin
            cond = q.cs2[q.d0[`PPI_D0_SEL +: 4]] ^ q.d0[`PPI_D0_POL];
            nxt = cond ? nxt_t : nxt_f;
            push = cap && (!ser || q.bcnt == `PPI_BCNT_LAST);
            stall = (push && !fifo_rdy) || (drv && !q.txf);
            if (!live) begin
               d.ph = ppi_pkg::PPI_IDLE;
            end else begin
               // control pins from the fetched output word
               d.ctl_o = mem_rd[15:0] & am;
               d.ctl_oe = (q.oen | (q.bid & mem_rd[`PPI_D1_OE +: 16])) & am;
               if (q.fae) begin
                  d.ctl_o[`PPI_FLAG_A_PIN] = buf_ready_i[q.fa];
                  d.ctl_oe[`PPI_FLAG_A_PIN] = 1'b1;
               end
               if (q.fbe) begin
                  d.ctl_o[`PPI_FLAG_B_PIN] = buf_ready_i[q.fb];
                  d.ctl_oe[`PPI_FLAG_B_PIN] = 1'b1;
               end
               // data pins, serial on lane bit 0 only
               d.pd_oe = drv ? (ser ? `PPI_LANE1 : lm) : '0;
               d.pd_o = ser ? {31'h0, q.tx[q.bcnt]} : (q.tx & lm);
               if (!stall) begin
                  if (cap) begin
                     d.rx = ser ? {q.rx[30:0], q.ps2[0]} : (q.ps2 & lm);
                  end
                  if (push) begin
                     fifo_wr = 1'b1;
                     fifo_in = {bufsel(q.cs2, q.ext), d.rx};
                  end
                  if (ser && (cap || drv)) begin
                     d.bcnt = q.bcnt + 1'b1;
                  end
                  if (drv && (!ser || q.bcnt == `PPI_BCNT_LAST)) begin
                     d.txf = 1'b0;
                  end
                  d.cur = nxt;
                  d.ph = ppi_pkg::PPI_FETCH_A;
               end
            end
         end
      endcase
      // outbound word from the DMA stream
      if (q.in_rdy && dma_in_valid) begin
         d.tx = dma_in_data;
         d.txf = 1'b1;
      end
      d.in_rdy = !d.txf;
      // quiet pins whenever idle
      if (d.ph == ppi_pkg::PPI_IDLE) begin
         d.ctl_o = '0;
         d.ctl_oe = '0;
         d.pd_o = '0;
         d.pd_oe = '0;
      end
   end
   // state register, frozen while ce is low
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
   // ****************************************
   // memory and inbound buffer
   // ****************************************
   ppi_wave_mem u_mem (
      .clk(ref_clk),
      .ce(ce),
      .we(mem_we),
      .waddr(q.daddr),
      .wdata(wb_dat_i),
      .re(mem_re),
      .raddr(mem_ra),
      .rdata(mem_rd)
   );
   ppi_fifo #(.W(37), .D(`PPI_FIFO_DEPTH)) u_fifo (
      .clk(ref_clk),
      .rst(sys_rst),
      .ce(ce),
      .in_valid(fifo_wr),
      .in_data(fifo_in),
      .in_ready(fifo_rdy),
      .out_ready(dma_out_ready),
      .out_valid(dma_out_valid),
      .out_data(fifo_out),
      .level(fifo_lvl)
   );
   // outputs
   assign dma_out_data = fifo_out[31:0];
   assign dma_out_buf = fifo_out[36:32];
   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign ctl_o = q.ctl_o;
   assign ctl_oe = q.ctl_oe;
   assign pd_o = q.pd_o;
   assign pd_oe = q.pd_oe;
   assign dma_in_ready = q.in_rdy;
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_fetch_ab;
      (q.ph == ppi_pkg::PPI_FETCH_A) && ce ##1 (q.ph == ppi_pkg::PPI_FETCH_B) && ce;
   endsequence
   sequence s_run_go;
      (q.ph == ppi_pkg::PPI_RUN) && ce && live && !stall;
   endsequence
   a_bus_ack: assert property ((wb_cyc_i && wb_stb_i && !q.ack && ce) |=> q.ack ##1 (!q.ack || !ce))
      else $error("ack not one cycle after request");
   a_fetch_order: assert property (s_fetch_ab |=> q.ph == ppi_pkg::PPI_RUN)
      else $error("fetch did not reach run");
   a_idle_quiet: assert property ((q.ph == ppi_pkg::PPI_IDLE) |-> (q.ctl_oe == '0 && q.pd_oe == '0))
      else $error("pins driven while idle");
   a_start_gate: assert property ((q.ph == ppi_pkg::PPI_IDLE && !live && ce) |=> q.ph == ppi_pkg::PPI_IDLE)
      else $error("engine left idle without enable and descriptor");
   a_slave_wait: assert property ((q.ph == ppi_pkg::PPI_IDLE && !q.mst && !q.cs2[`PPI_SEL_PIN] && ce) |=> q.ph == ppi_pkg::PPI_IDLE)
      else $error("slave started without select");
   a_branch_pick: assert property (s_run_go |=> q.cur == ($past(cond) ? $past(nxt_t) : $past(nxt_f)))
      else $error("wrong next state");
   a_out_desc: assert property ((q.ph == ppi_pkg::PPI_RUN && ce && live && !q.fae && !q.fbe) |=> q.ctl_o == ($past(d1_lo) & $past(am)))
      else $error("control outputs differ from descriptor");
   a_lane_8bit: assert property ((q.ph == ppi_pkg::PPI_RUN && ce && live && q.wid == ppi_pkg::PPI_W8) |=> q.pd_oe[31:8] == 24'h00_0000)
      else $error("upper lanes driven in 8-bit mode");
   a_ctl_w32: assert property ((q.ph == ppi_pkg::PPI_RUN && ce && live && q.wid == ppi_pkg::PPI_W32) |=> q.ctl_oe[15:14] == 2'h0)
      else $error("absent control pins driven");
   a_pin_hold: assert property (($changed(q.pd_o) && q.ph != ppi_pkg::PPI_IDLE) |=> ($stable(q.pd_o) || q.ph == ppi_pkg::PPI_IDLE))
      else $error("data pins changed faster than interface rate");
   a_buf_std: assert property ((fifo_wr && !q.ext) |-> fifo_in[36:34] == 3'h0)
      else $error("buffer beyond four without extended option");
   a_serial_word: assert property ((q.ph == ppi_pkg::PPI_RUN && ser && cap && q.bcnt != `PPI_BCNT_LAST) |-> !fifo_wr)
      else $error("serial word pushed early");
endmodule

// >>> tb/ppi_far_model.sv
`timescale 1ns/1ps
// ****************************************
// far party on the parallel pins
// ****************************************
module ppi_far_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic cond,
   input wire logic [4:0] bsel,
   input wire logic [31:0] word,
   input wire logic [15:0] ctl_o,
   input wire logic [15:0] ctl_oe,
   input wire logic [31:0] pd_o,
   input wire logic [31:0] pd_oe,
   output logic [15:0] ctl_i,
   output logic [31:0] pd_i
);
   logic tick_q;
   logic [15:0] drv_q;
   logic [31:0] dat_q;
   // pins change on every second edge only
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_q <= 1'b0;
         drv_q <= 16'h0000;
         dat_q <= 32'h0000_0000;
      end else begin
         tick_q <= ~tick_q;
         if (tick_q) begin
            drv_q <= {8'h00, bsel, 1'b0, cond, go};
            dat_q <= word;
         end
      end
   end
   // a pin driven by the core shows the core's value
   assign ctl_i = (ctl_oe & ctl_o) | (~ctl_oe & drv_q);
   assign pd_i = (pd_oe & pd_o) | (~pd_oe & dat_q);
endmodule

// >>> tb/ppi_core_tb.sv
`timescale 1ns/1ps
module ppi_core_tb;
   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] wr;
      logic [31:0] rd;
   } ppi_reg_row_type;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] dat;
      logic [4:0] bid;
      logic [15:0] oe;
   } ppi_mode_row_type;
   logic ref_clk, sys_rst, wb_req, wb_we, wb_ack, dov, dor, go, cond;
   logic [7:0] wb_adr;
   logic [31:0] wb_wdat, wb_rdat, rd, pd_i, pd_o, pd_oe, dod, word;
   logic [15:0] ctl_i, ctl_o, ctl_oe;
   logic [4:0] dob, bsel;
   logic div, dir;
   logic [31:0] did, bufr;
   int errors, check_count, cycles, n;
   ppi_reg_row_type regs [5];
   ppi_mode_row_type modes [5];
   ppi_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1), .wb_cyc_i(wb_req),
      .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ctl_i(ctl_i),
      .ctl_o(ctl_o), .ctl_oe(ctl_oe), .pd_i(pd_i), .pd_o(pd_o), .pd_oe(pd_oe),
      .buf_ready_i(bufr), .dma_out_valid(dov), .dma_out_ready(dor),
      .dma_out_data(dod), .dma_out_buf(dob), .dma_in_valid(div),
      .dma_in_data(did), .dma_in_ready(dir));
   ppi_far_model u_far (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go), .cond(cond),
      .bsel(bsel), .word(word), .ctl_o(ctl_o), .ctl_oe(ctl_oe), .pd_o(pd_o),
      .pd_oe(pd_oe), .ctl_i(ctl_i), .pd_i(pd_i));
   // ****************************************
   // clock, timeout and helpers
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      wb_req <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      wb_req <= 1'b0;
      wb_we <= 1'b0;
      check(k, 32'h0000_0002);
   endtask
   task automatic wait_oe(input logic [15:0] v);
      int k;
      k = 0;
      while ((ctl_oe & ctl_o) !== v && k < 200) begin
         @(posedge ref_clk);
         k++;
      end
      check({16'h0000, ctl_oe & ctl_o}, {16'h0000, v});
   endtask
   task automatic wait_level(input logic [4:0] v);
      int k;
      k = 0;
      do begin
         wb(1'b0, 8'h04, 32'h0000_0000);
         k++;
      end while (rd[20:16] !== v && k < 100);
      check({27'h0, rd[20:16]}, {27'h0, v});
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      regs = '{'{8'h08, 32'hFFFF_FFFF, 32'hFFFF_FFFF}, '{8'h0C, 32'hFFFF_FFFF, 32'h0000_07FF},
         '{8'h18, 32'hFFFF_FFFF, 32'h0000_3F3F}, '{8'h1C, 32'hFFFF_FFFF, 32'h0000_0000},
         '{8'h00, 32'hFFFF_FFE0, 32'h0000_0000}};
      modes = '{'{32'h0000_0003, 32'h0000_0078, 5'h02, 16'hC100},
         '{32'h0000_0007, 32'h0000_5678, 5'h02, 16'hC100},
         '{32'h0000_000B, 32'h1234_5678, 5'h02, 16'h0100},
         '{32'h0000_001B, 32'h1234_5678, 5'h1A, 16'h0100},
         '{32'h0000_000F, 32'h0000_0078, 5'h02, 16'hC100}};
      sys_rst = 1'b1;
      {wb_req, wb_we, go, cond} = 4'h0;
      wb_adr = 8'h00;
      wb_wdat = 32'h0000_0000;
      dor = 1'b1;
      div = 1'b0;
      did = 32'hA5A5_5A5B;
      bufr = 32'h0000_0004;
      bsel = 5'h1A;
      word = 32'h1234_5678;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      check({16'h0000, ctl_oe}, 32'h0000_0000);
      wb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check({31'h0, dir}, 32'h0000_0001);
      $display("test reset done");
      foreach (regs[i]) begin
         wb(1'b1, regs[i].adr, regs[i].wr);
         wb(1'b0, regs[i].adr, 32'h0000_0000);
         check(rd, regs[i].rd);
      end
      $display("test registers done");
      // two states: 0 captures until pin 1 rises, 1 holds
      wb(1'b1, 8'h08, 32'h0000_C300);
      wb(1'b1, 8'h18, 32'h0000_0000);
      wb(1'b1, 8'h0C, 32'h0000_0000);
      wb(1'b1, 8'h10, 32'h0041_0001);
      wb(1'b1, 8'h10, 32'h0000_C100);
      wb(1'b1, 8'h0C, 32'h0000_0008);
      wb(1'b1, 8'h10, 32'h0001_0101);
      wb(1'b1, 8'h10, 32'h0000_0200);
      wb(1'b1, 8'h00, 32'h0000_0003);
      repeat (20) @(posedge ref_clk);
      check({16'h0000, ctl_oe}, 32'h0000_0000);
      wb(1'b1, 8'h14, 32'h0000_0001);
      foreach (modes[i]) begin
         cond <= 1'b0;
         wb(1'b1, 8'h00, modes[i].ctrl);
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (!(dov === 1'b1 && dor === 1'b1) && n < 200);
         check(dod, modes[i].dat);
         check({27'h0, dob}, {27'h0, modes[i].bid});
         check({16'h0000, ctl_oe & ctl_o}, {16'h0000, modes[i].oe});
         cond <= 1'b1;
         wait_oe(16'h0200);
         wb(1'b1, 8'h00, 32'h0000_0000);
         wait_oe(16'h0000);
         check({16'h0000, ctl_oe}, 32'h0000_0000);
         $display("test mode %0d done", i);
      end
      // dma side stalls until the fifo refuses, then drains
      dor <= 1'b0;
      cond <= 1'b0;
      wb(1'b1, 8'h00, 32'h0000_000B);
      wait_level(5'd16);
      cond <= 1'b1;
      dor <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         if (dov === 1'b1) check(dod, 32'h1234_5678);
      end while (!((ctl_oe & ctl_o) === 16'h0200 && dov === 1'b0) && n < 300);
      wait_level(5'd0);
      $display("test fifo done");
      // slave start waits for pin 0
      cond <= 1'b0;
      wb(1'b1, 8'h00, 32'h0000_0000);
      wait_oe(16'h0000);
      check({16'h0000, ctl_oe}, 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_0001);
      repeat (20) @(posedge ref_clk);
      check({16'h0000, ctl_oe}, 32'h0000_0000);
      go <= 1'b1;
      wait_oe(16'hC100);
      sys_rst <= 1'b1;
      @(posedge ref_clk);
      check({16'h0000, ctl_oe}, 32'h0000_0000);
      sys_rst <= 1'b0;
      $display("test slave and reset done");
      // after reset: flag pin with parallel, then serial data drive
      div <= 1'b1;
      wb(1'b1, 8'h08, 32'h0000_C300);
      wb(1'b1, 8'h18, 32'h0000_0022);
      for (int s = 0; s < 2; s++) begin
         wb(1'b1, 8'h0C, 32'h0000_0000);
         wb(1'b1, 8'h10, (s == 0) ? 32'h0020_0000 : 32'h00A0_0000);
         wb(1'b1, 8'h10, 32'h0000_C100);
         wb(1'b1, 8'h14, 32'h0000_0001);
         wb(1'b1, 8'h00, 32'h0000_000B);
         wait_oe(16'h1100);
         n = 0;
         while (pd_oe !== ((s == 0) ? 32'hFFFF_FFFF : 32'h0000_0001) && n < 200) begin
            @(posedge ref_clk);
            n++;
         end
         check(pd_oe, (s == 0) ? 32'hFFFF_FFFF : 32'h0000_0001);
         check(pd_o, (s == 0) ? 32'hA5A5_5A5B : 32'h0000_0001);
         wb(1'b1, 8'h00, 32'h0000_0000);
      end
      $display("test drive done");
      close_out();
   end
endmodule
